/* src/tap_pkg.sv */
/*
  Shared constants and types of the tap detector: register offsets, field
  positions, reset values and the carrier structs.
  Assumes a 32-bit AHB-Lite register bus and a 12-bit three-axis sample feed.
*/
package tap_pkg;

  localparam int ACC_W = 12;
  localparam int TMR_W = 8;
  localparam int AXES = 3;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THR_X = 8'h04;
  localparam logic [7:0] OFF_THR_Y = 8'h08;
  localparam logic [7:0] OFF_THR_Z = 8'h0c;
  localparam logic [7:0] OFF_LIMIT = 8'h10;
  localparam logic [7:0] OFF_LATENCY = 8'h14;
  localparam logic [7:0] OFF_WINDOW = 8'h18;
  localparam logic [7:0] OFF_TAP_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

  // field positions
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_IGNLAT = 1;
  localparam int CTRL_SP_LSB = 2;
  localparam int CTRL_DP_LSB = 5;
  localparam int CTRL_W = 8;
  localparam int STAT_W = 6;
  localparam int IRQ_SINGLE = 0;
  localparam int IRQ_DOUBLE = 1;
  localparam int IRQ_W = 2;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h01;
  localparam logic [ACC_W-1:0] THR_RST = 12'h100;
  localparam logic [TMR_W-1:0] LIMIT_RST = 8'h06;
  localparam logic [TMR_W-1:0] LATENCY_RST = 8'h0a;
  localparam logic [TMR_W-1:0] WINDOW_RST = 8'h1e;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // one three-axis sample, x in slot 0
  typedef struct packed {
    logic [AXES-1:0][ACC_W-1:0] axis;
  } accel_s;

  typedef struct packed {
    logic [AXES-1:0] dpEn;
    logic [AXES-1:0] spEn;
    logic ignoreLat;
    logic latchEn;
  } ctrl_s;

  // tap status word: axis flags, double, single, combined event
  typedef struct packed {
    logic [AXES-1:0] axisHit;
    logic dbl;
    logic single;
    logic evt;
  } tap_stat_s;

  typedef enum logic [0:0] {
    TAP_IDLE,
    TAP_WAIT_SECOND
  } tap_state_e;

endpackage

/* src/tap_pulse_detector.sv */
/*
  Single and double tap detector with its AHB-Lite register file.
  Assumes samples arrive on core_clk with a one-cycle valid strobe from
  logic in the same domain; all timers count samples, not clock cycles.
*/
// Functional notes
// (R01) each axis magnitude is compared with its own threshold; smaller pulses ignored
// (R02) with latching on, tap event and its interrupt hold until status read
// (R03) latching off: interrupt follows the event, status shows latest event only
// (R04) latching off may give several interrupts per tap; latching is advised
// (R05) a pulse lasting longer than the time limit is no tap
// (R06) single pulse enable per axis; only enabled axes raise single events
// (R07) double pulse enable per axis; double taps only on enabled axes
// (R08) after a pulse a latency period runs; pulses inside it are ignored
// (R09) second-pulse window after a first pulse; later pulses start anew
// (R10) ignore-latency option bypasses the latency timer
// (R11) combined event flag plus per-axis flags name the triggering axis
module tap_pulse_detector
  import tap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // sample feed
  input wire logic sampleValid,
  input wire accel_s sample,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // interrupts
  output logic tapInt,
  output logic irq
);

  // magnitude of a two's complement sample
  function automatic logic [ACC_W-1:0] magOf(input logic [ACC_W-1:0] v);
    magOf = v[ACC_W-1] ? ACC_W'(~v + 1'b1) : v;
  endfunction

  // only the low 256 bytes decode; reads above give zero, writes there are dropped
  function automatic logic inMap(input logic [31:0] a);
    inMap = a[31:8] == 24'h000000;
  endfunction

  ctrl_s ctrl_q, ctrl_d;
  logic [AXES-1:0][ACC_W-1:0] thr_q, thr_d;
  logic [TMR_W-1:0] limit_q, limit_d;
  logic [TMR_W-1:0] latency_q, latency_d;
  logic [TMR_W-1:0] window_q, window_d;
  tap_stat_s stat_q, stat_d;
  logic [IRQ_W-1:0] irqStat_q, irqStat_d;
  logic [IRQ_W-1:0] irqMask_q, irqMask_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic wrPend_q, wrPend_d;
  logic [7:0] wrAddr_q, wrAddr_d;
  logic tapInt_q, tapInt_d;
  logic irq_q, irq_d;
  logic hreadyout_q;
  logic hresp_q;

  logic accept;
  logic rdAccept;
  logic statRead;
  logic [7:0] aOff;

  // address phase decode, zero wait states
  // hsize is not decoded: every register is one whole word
  always_comb begin
    accept = hsel && hready && (htrans == HTRANS_NONSEQ);
    rdAccept = accept && !hwrite;
    aOff = haddr[7:0];
    statRead = rdAccept && (aOff == OFF_TAP_STAT) && inMap(haddr);
  end

  // per-axis pulse qualification
  logic [AXES-1:0] above_q, above_d;
  logic [AXES-1:0] tooLong_q, tooLong_d;
  logic [AXES-1:0][TMR_W-1:0] dur_q, dur_d;
  logic [AXES-1:0] pulse;

  genvar gi;
  generate
    for (gi = 0; gi < AXES; gi++) begin : g_axis
      logic over;
      // a pulse ends when magnitude drops back under threshold
      // the run count stops at the limit, so a long press never wraps back into a tap
      always_comb begin
        over = magOf(sample.axis[gi]) >= thr_q[gi]; // see (R01)
        above_d[gi] = above_q[gi];
        tooLong_d[gi] = tooLong_q[gi];
        dur_d[gi] = dur_q[gi];
        pulse[gi] = 1'b0;
        if (sampleValid) begin
          above_d[gi] = over;
          if (over) begin
            if (!above_q[gi]) begin
              dur_d[gi] = TMR_W'(1);
              tooLong_d[gi] = 1'b0;
            end else if (dur_q[gi] >= limit_q) begin
              tooLong_d[gi] = 1'b1; // see (R05)
            end else begin
              dur_d[gi] = dur_q[gi] + 1'b1;
            end
          end else if (above_q[gi]) begin
            pulse[gi] = !tooLong_q[gi]; // see (R05)
          end
        end
      end

      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          above_q[gi] <= 1'b0;
          tooLong_q[gi] <= 1'b0;
          dur_q[gi] <= '0;
        end else begin
          above_q[gi] <= above_d[gi];
          tooLong_q[gi] <= tooLong_d[gi];
          dur_q[gi] <= dur_d[gi];
        end
      end
    end
  endgenerate

  // tap sequencing: latency lockout and second-pulse window
  // lockout counts on even when ignored, so dropping the option resumes it in step
  tap_state_e state_q, state_d;
  logic [TMR_W-1:0] latCnt_q, latCnt_d;
  logic [TMR_W-1:0] winCnt_q, winCnt_d;
  logic [AXES-1:0] live;
  logic [AXES-1:0] singleHit;
  logic [AXES-1:0] doubleHit;
  logic locked;
  logic expired;

  always_comb begin
    state_d = state_q;
    latCnt_d = latCnt_q;
    winCnt_d = winCnt_q;
    singleHit = '0;
    doubleHit = '0;
    locked = (latCnt_q != '0) && !ctrl_q.ignoreLat; // see (R08) (R10)
    live = locked ? '0 : pulse; // see (R08)
    expired = (state_q == TAP_WAIT_SECOND) && (winCnt_q >= window_q);
    if (sampleValid) begin
      if (latCnt_q != '0) begin
        latCnt_d = latCnt_q - 1'b1;
      end
      if (state_q == TAP_WAIT_SECOND) begin
        winCnt_d = winCnt_q + 1'b1;
      end
      if (expired) begin
        state_d = TAP_IDLE; // see (R09)
      end
      case (state_q)
        TAP_IDLE: begin
          singleHit = live & ctrl_q.spEn; // see (R06)
          if ((live & ctrl_q.dpEn) != '0) begin // see (R07)
            state_d = TAP_WAIT_SECOND;
            winCnt_d = '0;
          end
        end
        TAP_WAIT_SECOND: begin
          if (expired) begin
            // late pulse counts as a fresh first pulse
            singleHit = live & ctrl_q.spEn; // see (R09)
            if ((live & ctrl_q.dpEn) != '0) begin
              state_d = TAP_WAIT_SECOND;
              winCnt_d = '0;
            end
          end else begin
            doubleHit = live & ctrl_q.dpEn; // see (R07)
            singleHit = (doubleHit == '0) ? (live & ctrl_q.spEn) : '0;
            if (doubleHit != '0) begin
              state_d = TAP_IDLE;
            end
          end
        end
        default: begin
          state_d = TAP_IDLE;
        end
      endcase
      if (live != '0) begin
        latCnt_d = latency_q; // see (R08)
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= TAP_IDLE;
      latCnt_q <= '0;
      winCnt_q <= '0;
    end else begin
      state_q <= state_d;
      latCnt_q <= latCnt_d;
      winCnt_q <= winCnt_d;
    end
  end

  // tap status: sticky until read when latched, else latest sample only
  // a latched event survives any number of samples; only a status read clears it
  logic anyHit;
  always_comb begin
    anyHit = (singleHit | doubleHit) != '0;
    stat_d = stat_q;
    if (ctrl_q.latchEn) begin
      if (statRead) begin
        stat_d = '0; // see (R02)
      end
      if (anyHit) begin
        // new event wins over a read in the same cycle
        stat_d.evt = 1'b1; // see (R11)
        stat_d.single = stat_q.single | (singleHit != '0);
        stat_d.dbl = stat_q.dbl | (doubleHit != '0);
        stat_d.axisHit = stat_q.axisHit | singleHit | doubleHit; // see (R11)
      end
    end else if (sampleValid) begin
      // unlatched: only the event of this sample shows, can repeat per tap
      stat_d.evt = anyHit; // see (R03) (R04)
      stat_d.single = singleHit != '0;
      stat_d.dbl = doubleHit != '0;
      stat_d.axisHit = singleHit | doubleHit; // see (R11)
    end
    tapInt_d = stat_d.evt; // see (R02) (R03)
  end

  // interrupt status and mask, write one to clear
  // irq is built from next status and mask, so it never lags the registers
  always_comb begin
    irqStat_d = irqStat_q;
    if (wrPend_q && wrAddr_q == OFF_IRQ_STAT) begin
      irqStat_d = irqStat_q & ~hwdata[IRQ_W-1:0];
    end
    // set wins over a clear in the same cycle
    irqStat_d[IRQ_SINGLE] = irqStat_d[IRQ_SINGLE] | (singleHit != '0);
    irqStat_d[IRQ_DOUBLE] = irqStat_d[IRQ_DOUBLE] | (doubleHit != '0);
    irq_d = (irqStat_d & irqMask_d) != '0;
  end

  // register writes land in the data phase
  always_comb begin
    ctrl_d = ctrl_q;
    thr_d = thr_q;
    limit_d = limit_q;
    latency_d = latency_q;
    window_d = window_q;
    irqMask_d = irqMask_q;
    wrPend_d = accept && hwrite && inMap(haddr);
    wrAddr_d = accept ? aOff : wrAddr_q;
    // read-only and unmapped offsets fall into the default and change nothing
    if (wrPend_q) begin
      case (wrAddr_q)
        OFF_CTRL: ctrl_d = ctrl_s'(hwdata[CTRL_W-1:0]);
        OFF_THR_X: thr_d[0] = hwdata[ACC_W-1:0];
        OFF_THR_Y: thr_d[1] = hwdata[ACC_W-1:0];
        OFF_THR_Z: thr_d[2] = hwdata[ACC_W-1:0];
        OFF_LIMIT: limit_d = hwdata[TMR_W-1:0];
        OFF_LATENCY: latency_d = hwdata[TMR_W-1:0];
        OFF_WINDOW: window_d = hwdata[TMR_W-1:0];
        OFF_IRQ_MASK: irqMask_d = hwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // read data captured at the address phase; unmapped reads give zero
  // capturing early costs a register but keeps hrdata straight from a flop
  always_comb begin
    hrdata_d = hrdata_q;
    if (rdAccept) begin
      hrdata_d = '0;
      if (inMap(haddr)) begin
        case (aOff)
          OFF_CTRL: hrdata_d = 32'(ctrl_q);
          OFF_THR_X: hrdata_d = 32'(thr_q[0]);
          OFF_THR_Y: hrdata_d = 32'(thr_q[1]);
          OFF_THR_Z: hrdata_d = 32'(thr_q[2]);
          OFF_LIMIT: hrdata_d = 32'(limit_q);
          OFF_LATENCY: hrdata_d = 32'(latency_q);
          OFF_WINDOW: hrdata_d = 32'(window_q);
          OFF_TAP_STAT: hrdata_d = 32'(stat_q);
          OFF_IRQ_STAT: hrdata_d = 32'(irqStat_q);
          OFF_IRQ_MASK: hrdata_d = 32'(irqMask_q);
          default: hrdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= ctrl_s'(CTRL_RST);
      thr_q <= {AXES{THR_RST}};
      limit_q <= LIMIT_RST;
      latency_q <= LATENCY_RST;
      window_q <= WINDOW_RST;
      irqMask_q <= '0;
      irqStat_q <= '0;
      stat_q <= '0;
      hrdata_q <= '0;
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
      tapInt_q <= 1'b0;
      irq_q <= 1'b0;
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      thr_q <= thr_d;
      limit_q <= limit_d;
      latency_q <= latency_d;
      window_q <= window_d;
      irqMask_q <= irqMask_d;
      irqStat_q <= irqStat_d;
      stat_q <= stat_d;
      hrdata_q <= hrdata_d;
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      tapInt_q <= tapInt_d;
      irq_q <= irq_d;
      hreadyout_q <= 1'b1; // never stalls
      hresp_q <= 1'b0; // every transfer answers okay
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  // hreadyout stays low in reset, so no transfer is taken before registers settle
  assign hresp = hresp_q;
  assign tapInt = tapInt_q;
  assign irq = irq_q;

endmodule

/* verification/ahb_host.sv */
/*
  Host model: single-word AHB-Lite reads and writes for the bench.
  Assumes one slave whose hreadyout is fed back as hready.
*/
module ahb_host
  import tap_pkg::*;
(
  // clock and slave answer
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // master request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // a wait ran out
  output logic hung
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hung} = '0;
    hsize = 3'h2;
  end
  // one transfer; released address and data lines carry inverted leftovers, hwrite keeps its last value
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1 && ++n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1 && ++n < 64);
    q = hrdata;
    hwdata <= ~d;
    hung <= (n >= 64);
  endtask
endmodule

/* verification/tap_pulse_detector_bench.sv */
/*
  Bench of the tap detector: sample driver, integer model of taps and
  interrupts, comparisons at every result.
  Assumes ahb_host as register master and the bound port checker.
*/
`define CHK(what, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin nFail++; $display("unexpected %s exp %0h got %0h", what, exp, got); end \
end
module tap_pulse_detector_bench
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, sys_rst = 1'b1, sampleValid = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, tapInt, irq, hung;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  accel_s sample = '0;
  int nFail = 0, comparisons = 0, expSt, irqM, maskM, rnd, fMask;
  // per test a control word and gap; per pulse (two a test) axis, length, size
  int tCtrl[7] = '{8'h21, 8'h21, 8'h21, 8'h23, 8'h05, 8'h1d, 8'h1c};
  int tGap[7] = '{2, 15, 45, 2, 15, 15, 15};
  int tAx[14] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 2, 1, 0, 0};
  int tDur[14] = '{2, 2, 2, 2, 2, 2, 2, 2, 2, 8, 2, 6, 2, 2};
  int tMag[14] = '{default: 12'h180};
  int rstVal[11] = '{CTRL_RST, THR_RST, THR_RST, THR_RST, LIMIT_RST, LATENCY_RST, WINDOW_RST,
    0, 0, 0, 0};
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  tap_pulse_detector i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sampleValid(sampleValid),
    .sample(sample), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tapInt(tapInt), .irq(irq));
  ahb_host i_host (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hung(hung));
  // a bus wait that ran out ends the run at once
  always @(posedge hung) begin
    nFail++;
    stopTest();
  end
  // one sample; the other axes carry small random noise well under threshold
  task automatic smp(input int ax, input int val);
    accel_s s;
    for (int i = 0; i < AXES; i++) s.axis[i] = 12'($urandom_range(12'h07f)) - 12'h040;
    if (ax >= 0) s.axis[ax] = val[ACC_W-1:0];
    @(posedge core_clk);
    sampleValid <= 1'b1;
    sample <= s;
    @(posedge core_clk);
    sampleValid <= 1'b0;
  endtask
  // integer model; returns the status word, leaves the unlatched result in raw
  function automatic int model(input int t, output int raw);
    int i, win;
    bit hit;
    raw = 0;
    win = 0;
    for (int p = 0; p < 2; p++) begin
      i = 2 * t + p;
      hit = tMag[i] >= THR_RST && tDur[i] <= LIMIT_RST;
      hit &= p == 0 || tCtrl[t][CTRL_IGNLAT] || tGap[t] > LATENCY_RST;
      if (tGap[t] >= WINDOW_RST) win = 0;
      if (hit && win && tCtrl[t][CTRL_DP_LSB + tAx[i]]) begin
        raw |= 5 | 8 << tAx[i];
        win = 0;
      end else if (hit) begin
        if (tCtrl[t][CTRL_SP_LSB + tAx[i]]) raw |= 3 | 8 << tAx[i];
        win = tCtrl[t][CTRL_DP_LSB + tAx[i]];
      end
    end
    return tCtrl[t][CTRL_LATCH] ? raw : 0;
  endfunction
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // reset, register reset values, then the tap table
  initial begin
    void'($urandom(43701));
    tMag[10] = 12'h0ff;
    tMag[11] = 12'h100;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      i_host.xfer(1'b0, 8'(4 * i), '0, q);
      `CHK("reset value", 32'(rstVal[i]), q)
      `CHK("bus response", 1'b0, hresp)
    end
    // threshold and timer registers take a random word, hand back their field, then get reset values back
    for (int i = 1; i < 7; i++) begin
      rnd = $urandom();
      fMask = i < 4 ? 12'hfff : 8'hff;
      i_host.xfer(1'b1, 8'(4 * i), 32'(rnd), q);
      i_host.xfer(1'b0, 8'(4 * i), '0, q);
      `CHK("register readback", 32'(rnd & fMask), q)
      i_host.xfer(1'b1, 8'(4 * i), 32'(rstVal[i]), q);
    end
    $display("register test done");
    foreach (tCtrl[t]) begin
      maskM = $urandom_range(3);
      i_host.xfer(1'b1, OFF_IRQ_MASK, 32'(maskM), q);
      i_host.xfer(1'b1, OFF_CTRL, 32'(tCtrl[t]), q);
      i_host.xfer(1'b0, OFF_TAP_STAT, '0, q);
      for (int p = 0; p < 2; p++) begin
        repeat (p ? tGap[t] : 4) smp(-1, 0);
        repeat (tDur[2 * t + p]) smp(tAx[2 * t + p], $urandom_range(1) ? tMag[2 * t + p] :
          -tMag[2 * t + p]);
      end
      repeat (35) smp(-1, 0);
      expSt = model(t, irqM);
      irqM = (irqM >> 1) & 3;
      `CHK("tap line", expSt != 0, tapInt)
      `CHK("irq line", (irqM & maskM) != 0, irq)
      i_host.xfer(1'b0, OFF_IRQ_STAT, '0, q);
      `CHK("irq status", 32'(irqM), q)
      i_host.xfer(1'b0, OFF_TAP_STAT, '0, q);
      `CHK("tap status", 32'(expSt), q)
      i_host.xfer(1'b1, OFF_IRQ_STAT, 32'(irqM), q);
      i_host.xfer(1'b0, OFF_TAP_STAT, '0, q);
      `CHK("status after read", 32'h0, q)
      `CHK("irq after clear", 1'b0, irq)
      $display("test %0d done", t);
    end
    stopTest();
  end
endmodule

/* verification/tap_pulse_detector_sva.sv */
/*
  Port checker of the tap detector: latching, clearing and interrupt relations.
  Assumes the tap_pkg register map and one clock domain.
*/
module tap_pulse_detector_sva
  import tap_pkg::*;
(
  // clock, reset and inputs
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sampleValid,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // outputs
  input wire logic [31:0] hrdata,
  input wire logic tapInt,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic rdStat, wrPend_q, rdStat_q;
  logic [7:0] wrAddr_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0] mask_q;
  // status read seen in an address phase
  assign rdStat = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
    && haddr == 32'(OFF_TAP_STAT);
  // shadow of control and mask, taken where the data phase ends
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      rdStat_q <= 1'b0;
      wrAddr_q <= '0;
      ctrl_q <= CTRL_RST;
      mask_q <= '0;
    end else begin
      wrPend_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
      rdStat_q <= rdStat;
      wrAddr_q <= haddr[7:0];
      if (wrPend_q && wrAddr_q == OFF_CTRL) ctrl_q <= hwdata[CTRL_W-1:0];
      if (wrPend_q && wrAddr_q == OFF_IRQ_MASK) mask_q <= hwdata[IRQ_W-1:0];
    end
  end
  tap_cause_a: assert property ($rose(tapInt) |-> $past(sampleValid) || $past(sampleValid, 2))
    else $error("tap line rose with no sample before it");
  irq_cause_a: assert property ($rose(irq) |-> $past(sampleValid) || $past(sampleValid, 2)
    || $past(sampleValid, 3) || $past(wrPend_q) || $past(wrPend_q, 2))
    else $error("interrupt rose with no event or mask write");
  latch_hold_a: assert property (ctrl_q[CTRL_LATCH] && tapInt && !rdStat && !$past(rdStat)
    |=> tapInt || !ctrl_q[CTRL_LATCH]) else $error("latched tap dropped without a read");
  read_clear_a: assert property (ctrl_q[CTRL_LATCH] && rdStat && !sampleValid
    && !$past(sampleValid) && !$past(sampleValid, 2) ##1 !sampleValid |=> !tapInt)
    else $error("status read left the tap line high");
  unlatch_drop_a: assert property (!ctrl_q[CTRL_LATCH] && !ctrl_q[CTRL_IGNLAT] && tapInt
    && sampleValid |-> ##[1:2] !tapInt) else $error("unlatched tap outlived its event");
  tap_stable_a: assert property ((!sampleValid && !rdStat) [*3] |=> $stable(tapInt))
    else $error("tap line moved with no sample or read");
  irq_mask_a: assert property (mask_q == '0 && $past(mask_q) == '0 |-> !irq)
    else $error("interrupt high while fully masked");
  stat_flags_a: assert property (rdStat_q |-> hrdata[31:6] == '0
    && hrdata[0] == (hrdata[1] | hrdata[2]) && hrdata[0] == (|hrdata[5:3]))
    else $error("event, kind and axis flags disagree");
  // main scenarios reached
  cover property (rdStat_q && hrdata[2]);
  cover property ($rose(irq));
  cover property (!ctrl_q[CTRL_LATCH] && $fell(tapInt));
endmodule

bind tap_pulse_detector tap_pulse_detector_sva i_sva (.core_clk(core_clk), .sys_rst(sys_rst),
  .sampleValid(sampleValid), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .tapInt(tapInt), .irq(irq));
